/* File: verilog/stm_pkg.sv */
// Package of register offsets, field positions and codes for the standard timer
`default_nettype none
package stm_pkg;
	// ************************************************************
	// Register map (byte addresses, one aligned word each)
	// ************************************************************
	localparam logic [7:0] OFS_CTRL0    = 8'h00;
	localparam logic [7:0] OFS_CTRL1    = 8'h04;
	localparam logic [7:0] OFS_CNT_LO   = 8'h08;
	localparam logic [7:0] OFS_CNT_HI   = 8'h0C;
	localparam logic [7:0] OFS_CMPA_LO  = 8'h10;
	localparam logic [7:0] OFS_CMPA_HI  = 8'h14;
	localparam logic [7:0] OFS_CMPP     = 8'h18;
	localparam logic [7:0] OFS_FLAGS    = 8'h1C;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int C0_PAUSE  = 7;
	localparam int C0_CK_LO  = 4;
	localparam int C0_ON     = 3;
	localparam int C1_MODE_LO = 6;
	localparam int C1_PF_LO  = 4;
	localparam int C1_OC     = 3;
	localparam int C1_POL    = 2;
	localparam int C1_DPX    = 1;
	localparam int C1_CCLR   = 0;
	localparam int FL_A      = 0;
	localparam int FL_P      = 1;
	localparam logic [7:0] C0_MASK   = 8'hF8;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ************************************************************
	// Codes
	// ************************************************************
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_CAP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;
	localparam logic [1:0] PF_00    = 2'h0;
	localparam logic [1:0] PF_01    = 2'h1;
	localparam logic [1:0] PF_10    = 2'h2;
	localparam logic [1:0] PF_11    = 2'h3;
	localparam logic [2:0] CK_SYS4  = 3'h0;
	localparam logic [2:0] CK_SYS   = 3'h1;
	localparam logic [2:0] CK_H16   = 3'h2;
	localparam logic [2:0] CK_H64   = 3'h3;
	localparam logic [2:0] CK_SUBA  = 3'h4;
	localparam logic [2:0] CK_SUBB  = 3'h5;
	localparam logic [2:0] CK_EXTR  = 3'h6;
	localparam logic [2:0] CK_EXTF  = 3'h7;
	localparam logic [5:0] DIV4_LAST  = 6'h03;
	localparam logic [5:0] DIV16_LAST = 6'h0F;
	localparam logic [5:0] DIV64_LAST = 6'h3F;
	// Single pulse sequencer states
	typedef enum logic [1:0] {
		SP_IDLE = 2'b01,
		SP_HIGH = 2'b10
	} stm_sp_t;
endpackage : stm_pkg
`default_nettype wire

/* File: verilog/stm_timer.sv */
// Standard 16-bit timer: APB registers, counter, comparators and output pin
`default_nettype none
module stm_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        high_clock_tick,
	input  wire logic        sub_clock,
	input  wire logic        external_clock_pin,
	input  wire logic        capture_input_pin,
	output logic             compare_output_pin,
	output logic             compare_output_oe,
	output logic             compare_a_flag,
	output logic             compare_p_flag,
	output logic             low_power
);
	import stm_pkg::*;

	// ************************************************************
	// Registers and decode
	// ************************************************************
	logic [7:0]  ctrl0_ff;
	logic [7:0]  ctrl1_ff;
	logic [15:0] cmpa_ff;
	logic [7:0]  cmpp_ff;
	logic [15:0] count_ff;
	logic [15:0] capt_ff;
	logic        flag_a_ff;
	logic        flag_p_ff;
	logic        on_d_ff;
	logic        out_ff;
	logic [5:0]  div_ff;
	logic [2:0]  ext_sync_ff;
	logic [2:0]  cap_sync_ff;
	logic [2:0]  sub_sync_ff;
	stm_sp_t     sp_ff;

	logic        wr_en;
	logic        on_bit;
	logic        on_rise;
	logic [1:0]  mode;
	logic [1:0]  pfun;
	logic        tick;
	logic        match_a;
	logic        match_p;
	logic        clr_cnt;
	logic        pwm_lvl;
	logic        cap_evt;
	logic        raw_out;

	// Register address match
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	assign wr_en   = psel && penable && pwrite;
	assign on_bit  = ctrl0_ff[C0_ON];
	assign on_rise = on_bit && !on_d_ff;
	assign mode    = ctrl1_ff[C1_MODE_LO +: 2];
	assign pfun    = ctrl1_ff[C1_PF_LO +: 2];
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign low_power = !on_bit;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	// Two stages, then a third stage for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync_ff <= 3'h0;
			cap_sync_ff <= 3'h0;
			sub_sync_ff <= 3'h0;
		end else begin
			ext_sync_ff <= {ext_sync_ff[1:0], external_clock_pin};
			cap_sync_ff <= {cap_sync_ff[1:0], capture_input_pin};
			sub_sync_ff <= {sub_sync_ff[1:0], sub_clock};
		end
	end

	// ************************************************************
	// Register writes
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_ff <= REG_RESET;
			ctrl1_ff <= REG_RESET;
			cmpa_ff  <= 16'h0000;
			cmpp_ff  <= REG_RESET;
		end else begin
			if (wr_en) begin
				if (hit(paddr, OFS_CTRL0))
					ctrl0_ff <= pwdata[7:0] & C0_MASK;
				if (hit(paddr, OFS_CTRL1))
					ctrl1_ff <= pwdata[7:0];
				if (hit(paddr, OFS_CMPA_LO))
					cmpa_ff[7:0] <= pwdata[7:0];
				if (hit(paddr, OFS_CMPA_HI))
					cmpa_ff[15:8] <= pwdata[7:0];
				if (hit(paddr, OFS_CMPP))
					cmpp_ff <= pwdata[7:0];
			end
			// Hardware end of a single pulse wins over a same-cycle write
			if (sp_ff == SP_HIGH && match_a && mode == MODE_PWM && pfun == PF_11)
				ctrl0_ff[C0_ON] <= 1'b0;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (1'b1)
			hit(paddr, OFS_CTRL0):   prdata[7:0] = ctrl0_ff;
			hit(paddr, OFS_CTRL1):   prdata[7:0] = ctrl1_ff;
			hit(paddr, OFS_CNT_LO):  prdata[7:0] = count_ff[7:0];
			hit(paddr, OFS_CNT_HI):  prdata[7:0] = count_ff[15:8];
			hit(paddr, OFS_CMPA_LO): prdata[7:0] = cmpa_ff[7:0];
			hit(paddr, OFS_CMPA_HI): prdata[7:0] = cmpa_ff[15:8];
			hit(paddr, OFS_CMPP):    prdata[7:0] = cmpp_ff;
			hit(paddr, OFS_FLAGS):   prdata[15:0] = capt_ff;
			default:                 prdata = 32'h0000_0000;
		endcase
	end

	// ************************************************************
	// Count clock selection
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_ff <= 6'h00;
		else
			div_ff <= div_ff + 6'h01;
	end

	// One count tick per selected source event
	always_comb begin
		unique case (ctrl0_ff[C0_CK_LO +: 3])
			CK_SYS4: tick = (div_ff[1:0] == DIV4_LAST[1:0]);
			CK_SYS:  tick = 1'b1;
			CK_H16:  tick = high_clock_tick && (div_ff[3:0] == DIV16_LAST[3:0]);
			CK_H64:  tick = high_clock_tick && (div_ff == DIV64_LAST);
			CK_SUBA, CK_SUBB: tick = sub_sync_ff[1] && !sub_sync_ff[2];
			CK_EXTR: tick = ext_sync_ff[1] && !ext_sync_ff[2];
			CK_EXTF: tick = !ext_sync_ff[1] && ext_sync_ff[2];
		endcase
	end

	// ************************************************************
	// Comparators and counter
	// ************************************************************
	assign match_a = tick && (count_ff == cmpa_ff);
	assign match_p = tick && (cmpp_ff == 8'h00 ? count_ff == 16'hFFFF
		: count_ff == {cmpp_ff, 8'hFF});
	// Clear source by mode and selects
	always_comb begin
		if (mode == MODE_PWM)
			clr_cnt = ctrl1_ff[C1_DPX] ? match_a : match_p;
		else if (mode == MODE_CAP)
			clr_cnt = match_p && cmpp_ff == 8'h00;
		else
			clr_cnt = ctrl1_ff[C1_CCLR] ? match_a : match_p;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= 16'h0000;
			on_d_ff  <= 1'b0;
		end else begin
			on_d_ff <= on_bit;
			if (on_rise)
				count_ff <= 16'h0000;
			else if (on_bit && !ctrl0_ff[C0_PAUSE] && tick)
				count_ff <= clr_cnt ? 16'h0000 : count_ff + 16'h0001;
		end
	end

	// Match flags, sticky until written one; set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_a_ff <= 1'b0;
			flag_p_ff <= 1'b0;
		end else begin
			if (on_bit && !ctrl0_ff[C0_PAUSE] && match_a)
				flag_a_ff <= 1'b1;
			else if (wr_en && hit(paddr, OFS_FLAGS) && pwdata[16 + FL_A])
				flag_a_ff <= 1'b0;
			if (on_bit && !ctrl0_ff[C0_PAUSE] && match_p
				&& !((mode == MODE_CMP || mode == MODE_TMR) && ctrl1_ff[C1_CCLR]))
				flag_p_ff <= 1'b1;
			else if (wr_en && hit(paddr, OFS_FLAGS) && pwdata[16 + FL_P])
				flag_p_ff <= 1'b0;
		end
	end
	assign compare_a_flag = flag_a_ff;
	assign compare_p_flag = flag_p_ff;

	// ************************************************************
	// Capture
	// ************************************************************
	always_comb begin
		unique case (pfun)
			PF_00: cap_evt = cap_sync_ff[1] && !cap_sync_ff[2];
			PF_01: cap_evt = !cap_sync_ff[1] && cap_sync_ff[2];
			PF_10: cap_evt = cap_sync_ff[1] != cap_sync_ff[2];
			PF_11: cap_evt = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			capt_ff <= 16'h0000;
		else if (mode == MODE_CAP && on_bit && cap_evt)
			capt_ff <= count_ff;
	end

	// ************************************************************
	// Output pin
	// ************************************************************
	// PWM active while count below duty value
	always_comb begin
		if (ctrl1_ff[C1_DPX])
			pwm_lvl = (cmpp_ff == 8'h00) || (count_ff < {cmpp_ff, 8'h00});
		else
			pwm_lvl = count_ff < cmpa_ff;
	end

	// Single pulse sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sp_ff <= SP_IDLE;
		else begin
			unique case (sp_ff)
				SP_IDLE: if (on_rise) sp_ff <= SP_HIGH;
				SP_HIGH: if (!on_bit || match_a) sp_ff <= SP_IDLE;
			endcase
		end
	end

	// Compare mode level register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			out_ff <= 1'b0;
		else if (on_rise)
			out_ff <= ctrl1_ff[C1_OC];
		else if (mode == MODE_CMP && on_bit && !ctrl0_ff[C0_PAUSE] && match_a) begin
			unique case (pfun)
				PF_00: out_ff <= out_ff;
				PF_01: out_ff <= 1'b0;
				PF_10: out_ff <= 1'b1;
				PF_11: out_ff <= !out_ff;
			endcase
		end
	end

	// Level before polarity, per mode
	always_comb begin
		raw_out = out_ff;
		if (mode == MODE_PWM) begin
			unique case (pfun)
				PF_00: raw_out = !ctrl1_ff[C1_OC];
				PF_01: raw_out = ctrl1_ff[C1_OC];
				PF_10: raw_out = (on_bit && pwm_lvl) == ctrl1_ff[C1_OC];
				PF_11: raw_out = (sp_ff == SP_HIGH) == ctrl1_ff[C1_OC];
			endcase
		end
	end

	assign compare_output_pin = (mode == MODE_TMR) ? 1'b0 : raw_out ^ ctrl1_ff[C1_POL];
	assign compare_output_oe  = (mode == MODE_CMP) || (mode == MODE_PWM);

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_on_rise;
		!on_bit ##1 on_bit;
	endsequence

	AST_CNT_LO: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !pwrite && hit(paddr, OFS_CNT_LO) |-> prdata[7:0] == count_ff[7:0])
		else $error("count low byte read mismatch");
	AST_CMPA_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit(paddr, OFS_CMPA_HI) |=> cmpa_ff[15:8] == $past(pwdata[7:0]))
		else $error("compare-A high byte not stored");
	AST_PAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl0_ff[C0_PAUSE] && on_d_ff && on_bit |=> $stable(count_ff))
		else $error("counter moved while paused");
	AST_ON_CLR: assert property (@(posedge pclk) disable iff (!presetn)
		on_rise |=> count_ff == 16'h0000)
		else $error("counter not cleared on enable");
	AST_OFF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!on_bit && !on_d_ff |=> $stable(count_ff))
		else $error("counter moved while off");
	AST_INIT_LVL: assert property (@(posedge pclk) disable iff (!presetn)
		s_on_rise |=> out_ff == $past(ctrl1_ff[C1_OC]))
		else $error("initial level not loaded");
	AST_SP_END: assert property (@(posedge pclk) disable iff (!presetn)
		sp_ff == SP_HIGH && match_a |=> sp_ff == SP_IDLE)
		else $error("single pulse not ended on compare-A match");
	AST_CLR_A: assert property (@(posedge pclk) disable iff (!presetn)
		mode == MODE_CMP && ctrl1_ff[C1_CCLR] && on_bit && !ctrl0_ff[C0_PAUSE] && match_a
		|=> count_ff == 16'h0000)
		else $error("compare-A match did not clear the counter");
	AST_TMR_PIN: assert property (@(posedge pclk) disable iff (!presetn)
		mode == MODE_TMR |-> !compare_output_oe)
		else $error("pin driven in timer mode");
	AST_NO_PF: assert property (@(posedge pclk) disable iff (!presetn)
		mode == MODE_CMP && ctrl1_ff[C1_CCLR] && !flag_p_ff |=> !flag_p_ff)
		else $error("compare-P flag raised with clear select high");
	AST_C0_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl0_ff[2:0] == 3'h0)
		else $error("unimplemented bits nonzero");
endmodule : stm_timer
`default_nettype wire

/* File: bench/stm_pin_model.sv */
// Model of the pins beyond the timer: external clock source and capture source
`default_nettype none
module stm_pin_model (
	input  wire logic pclk,
	output var logic  external_clock_pin,
	output var logic  capture_input_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Both lines rest low outside a burst
	initial begin
		external_clock_pin = 1'b0;
		capture_input_pin  = 1'b0;
	end
	// Burst of n pulses, three cycles a phase so the synchroniser sees each
	task automatic clk_pulses(input int n);
		repeat (n) begin
			repeat (3) @(posedge pclk);
			external_clock_pin <= 1'b1;
			repeat (3) @(posedge pclk);
			external_clock_pin <= 1'b0;
		end
	endtask : clk_pulses
	// One rise then one fall on the capture line
	task automatic cap_pulse();
		@(posedge pclk);
		capture_input_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		capture_input_pin <= 1'b0;
	endtask : cap_pulse
endmodule : stm_pin_model
`default_nettype wire

/* File: bench/stm_timer_tb.sv */
// Self-checking bench for the standard timer register block
`default_nettype none
module stm_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import stm_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] q, v;
	logic        sub_clk, ext_pin, cap_pin, pin, oe, fa, fp, lp;
	int          n_mismatch, checks, cyc, n;
	// Address, write value, read-back value
	localparam logic [23:0] REGS [8] = '{{OFS_CTRL0, 8'hE7, 8'hE0}, {OFS_CTRL1, 8'hA5, 8'hA5},
		{OFS_CNT_LO, 8'hFF, 8'h00}, {OFS_CNT_HI, 8'hFF, 8'h00}, {OFS_CMPA_LO, 8'h5A, 8'h5A},
		{OFS_CMPA_HI, 8'h80, 8'h80}, {OFS_CMPP, 8'hC3, 8'hC3}, {8'h20, 8'hFF, 8'h00}};
	// Control-1 value, expected pin, expected enable
	localparam logic [9:0] ROWS [9] = '{{8'h00, 2'h1}, {8'h08, 2'h3}, {8'h0C, 2'h1},
		{8'h04, 2'h3}, {8'h80, 2'h3}, {8'h88, 2'h1}, {8'h98, 2'h3}, {8'h9C, 2'h1}, {8'hC8, 2'h0}};
	// Counts expected per clock select code over one window
	localparam logic [7:0] TICKS [8] = '{8'h22, 8'h87, 8'h08, 8'h02, 8'h08, 8'h08, 8'h05, 8'h05};
	stm_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .high_clock_tick(1'b1), .sub_clock(sub_clk),
		.external_clock_pin(ext_pin), .capture_input_pin(cap_pin),
		.compare_output_pin(pin), .compare_output_oe(oe), .compare_a_flag(fa),
		.compare_p_flag(fp), .low_power(lp));
	stm_pin_model PM (.pclk(pclk), .external_clock_pin(ext_pin), .capture_input_pin(cap_pin));
	// Clock, slow sub clock and hang guard
	always #25 pclk = ~pclk;
	always begin
		repeat (8) @(posedge pclk);
		sub_clk <= ~sub_clk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	// One APB transfer; low half of read data lands in q
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Answer taken mid-cycle, where it stands until the closing edge
		do begin
			@(negedge pclk);
			rdy = pready;
			q = prdata[15:0];
			@(posedge pclk);
		end while (rdy !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			n_mismatch++;
		end
	endtask : chk
	// Cycles until the output pin changes, 1000 if it never does
	task automatic wait_pin();
		logic p0;
		p0 = pin;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (pin === p0 && n < 1000);
	endtask : wait_pin
	task automatic end_sim();
		$display("Comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{pclk, psel, penable, pwrite, sub_clk, presetn} = 6'h00;
		{paddr, pwdata, n_mismatch, checks, cyc} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, REGS[i][23:16], 32'h0);
			chk("reset value", 16'h0, {8'h0, q[7:0]});
			apb(1'b1, REGS[i][23:16], {24'h0, REGS[i][15:8]});
			apb(1'b0, REGS[i][23:16], 32'h0);
			chk("read back", {8'h0, REGS[i][7:0]}, {8'h0, q[7:0]});
		end
		$display("Test registers done");
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, OFS_CTRL0, 32'h10);
			apb(1'b1, OFS_CTRL1, {24'h0, ROWS[i][9:2]});
			apb(1'b1, OFS_CTRL0, 32'h18);
			repeat (2) @(posedge pclk);
			chk("pin level", {15'h0, ROWS[i][1]}, {15'h0, pin});
			chk("pin enable", {15'h0, ROWS[i][0]}, {15'h0, oe});
		end
		$display("Test pin levels done");
		apb(1'b1, OFS_CTRL0, 32'h0);
		apb(1'b1, OFS_CTRL1, 32'hC0);
		apb(1'b1, OFS_CTRL0, 32'h18);
		repeat (40) @(posedge pclk);
		apb(1'b1, OFS_CTRL0, 32'h98);
		apb(1'b0, OFS_CNT_LO, 32'h0);
		v = q;
		repeat (10) @(posedge pclk);
		apb(1'b0, OFS_CNT_LO, 32'h0);
		chk("paused", v, q);
		apb(1'b1, OFS_CTRL0, 32'h18);
		apb(1'b1, OFS_CTRL0, 32'h10);
		apb(1'b0, OFS_CNT_LO, 32'h0);
		chk("resumed", 16'h1, {15'h0, q[7:0] > v[7:0] && q[7:0] < v[7:0] + 8'h08});
		chk("low power", 16'h1, {15'h0, lp});
		v = q;
		repeat (10) @(posedge pclk);
		apb(1'b0, OFS_CNT_LO, 32'h0);
		chk("held", v, q);
		apb(1'b1, OFS_CTRL0, 32'h18);
		apb(1'b0, OFS_CNT_LO, 32'h0);
		chk("cleared", 16'h1, {15'h0, q[7:0] < 8'h06});
		$display("Test counter control done");
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, OFS_CTRL0, 32'h0);
			apb(1'b1, OFS_CTRL0, {24'h0, 1'b0, k[2:0], 4'h8});
			if (k > 5) PM.clk_pulses(5);
			else repeat (128) @(posedge pclk);
			repeat (4) @(posedge pclk);
			apb(1'b1, OFS_CTRL0, {24'h0, 1'b1, k[2:0], 4'h8});
			apb(1'b0, OFS_CNT_LO, 32'h0);
			n = int'(q[7:0]) - int'(TICKS[k]);
			chk("ticks", 16'h1, {15'h0, n >= -4 && n <= 4});
		end
		$display("Test clock select done");
		apb(1'b1, OFS_CTRL0, 32'h0);
		apb(1'b1, OFS_CMPA_HI, 32'h0);
		apb(1'b1, OFS_CMPA_LO, 32'h20);
		apb(1'b1, OFS_CMPP, 32'h01);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, OFS_CTRL0, 32'h0);
			apb(1'b1, OFS_FLAGS, 32'h30000);
			apb(1'b1, OFS_CTRL1, {24'h0, 7'h18, k[0] ^ 1'b1});
			apb(1'b1, OFS_CTRL0, 32'h18);
			wait_pin();
			wait_pin();
			chk("match period", k == 0 ? 16'h21 : 16'h200, 16'(n));
			chk("P flag", {15'h0, k[0]}, {15'h0, fp});
			chk("A flag", 16'h1, {15'h0, fa});
		end
		apb(1'b1, OFS_CTRL0, 32'h0);
		apb(1'b1, OFS_CTRL1, 32'h29);
		apb(1'b1, OFS_CTRL0, 32'h18);
		repeat (3) @(posedge pclk);
		wait_pin();
		chk("no visible change", 16'h3E8, 16'(n));
		apb(1'b1, OFS_CTRL0, 32'h0);
		apb(1'b1, OFS_CTRL1, 32'h19);
		apb(1'b1, OFS_CTRL0, 32'h18);
		repeat (40) @(posedge pclk);
		chk("driven low", 16'h0, {15'h0, pin});
		$display("Test compare match done");
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, OFS_CTRL0, 32'h0);
			apb(1'b1, OFS_CTRL1, {24'h0, 2'h1, k[1:0], 4'h0});
			apb(1'b1, OFS_CTRL0, 32'h18);
			repeat (8 * k) @(posedge pclk);
			apb(1'b1, OFS_CTRL0, 32'h98);
			apb(1'b0, OFS_CNT_LO, 32'h0);
			if (k < 3) v = q;
			PM.cap_pulse();
			repeat (6) @(posedge pclk);
			apb(1'b0, OFS_FLAGS, 32'h0);
			chk("capture", {8'h0, v[7:0]}, {8'h0, q[7:0]});
		end
		$display("Test capture done");
		apb(1'b1, OFS_CTRL0, 32'h0);
		apb(1'b1, OFS_CTRL1, 32'hA8);
		apb(1'b1, OFS_CTRL0, 32'h18);
		repeat (3) @(posedge pclk);
		chk("PWM start level", 16'h1, {15'h0, pin});
		wait_pin();
		wait_pin();
		chk("PWM low time", 16'h1E0, 16'(n));
		wait_pin();
		chk("PWM high time", 16'h20, 16'(n));
		$display("Test PWM done");
		apb(1'b1, OFS_CTRL0, 32'h0);
		apb(1'b1, OFS_CTRL1, 32'hB8);
		apb(1'b1, OFS_CTRL0, 32'h18);
		repeat (3) @(posedge pclk);
		chk("pulse active", 16'h1, {15'h0, pin});
		repeat (40) @(posedge pclk);
		chk("pulse ended", 16'h0, {15'h0, pin});
		apb(1'b0, OFS_CTRL0, 32'h0);
		chk("on bit cleared", 16'h10, q);
		$display("Test single pulse done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk("reset low power", 16'h1, {15'h0, lp});
		apb(1'b0, OFS_CTRL1, 32'h0);
		chk("reset control", 16'h0, q);
		chk("reset flags", 16'h0, {14'h0, fa, fp});
		$display("Test reset done");
		end_sim();
	end
endmodule : stm_timer_tb
`default_nettype wire
